// file: hw/status_pkg.sv
// constants and types shared by the status and error queue block
package status_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int GROUPS       = 3;
	localparam int DATA_W       = 16;
	localparam int CODE_W       = 16;
	localparam int RSP_W        = 32;
	localparam int QUEUE_DEPTH  = 10;
	localparam int LIST_ENTRIES = 4;

	// ----------------------------------------------------------------
	// group selects and bit layouts
	// ----------------------------------------------------------------
	localparam logic [1:0]  GRP_MEAS   = 2'h0;
	localparam logic [1:0]  GRP_QUES   = 2'h1;
	localparam logic [1:0]  GRP_OPER   = 2'h2;
	localparam logic [15:0] MEAS_USED  = 16'h03A7;
	localparam logic [15:0] QUES_USED  = 16'h4110;
	localparam logic [15:0] OPER_USED  = 16'h0430;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [15:0] EVT_RESET  = 16'h0000;

	// ----------------------------------------------------------------
	// message codes
	// ----------------------------------------------------------------
	localparam logic [15:0] OVERFLOW_CODE = 16'h015E;
	localparam logic [15:0] NO_ERROR_CODE = 16'h0000;

	// ----------------------------------------------------------------
	// host commands
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE,
		OP_MASK_WR,
		OP_MASK_RD,
		OP_COND_RD,
		OP_EVENT_RD,
		OP_PRESET,
		OP_QUEUE_RD,
		OP_QUEUE_CLR,
		OP_ENLIST_BEGIN,
		OP_ENLIST_ADD,
		OP_DISLIST_ADD,
		OP_LIST_RD
	} cmd_op_t;

endpackage

// file: hw/queue_mem_if.sv
// carrier between the queue control and its message store
`timescale 1ns/100ps
interface queue_mem_if #(parameter int WIDTH = 16, parameter int AW = 4);
	logic            wrEn;
	logic [AW-1:0]   wrAddr;
	logic [WIDTH-1:0] wrData;
	logic [AW-1:0]   rdAddr;
	logic [WIDTH-1:0] rdData;

	modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
	modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// file: hw/error_queue_mem.sv
// message store of the error queue, registered read data
`timescale 1ns/100ps
module error_queue_mem #(
	parameter int DEPTH = 10,
	parameter int WIDTH = 16
) (
	// clock
	input wire logic ref_clk,
	// access
	queue_mem_if.store mem
);

	logic [WIDTH-1:0] store [DEPTH];

	// no reset on the array; the control never reads a slot it has not written
	always_ff @(posedge ref_clk) begin
		if (mem.wrEn) begin
			store[mem.wrAddr] <= mem.wrData;
		end
	end

	always_ff @(posedge ref_clk) begin
		mem.rdData <= store[mem.rdAddr];
	end

endmodule

// file: hw/status_mask_and_error_queue.sv
// status condition, event and mask registers with the filtered error queue
`timescale 1ns/100ps
// Operation
// [R01] mask write loads all sixteen bits from the value; zero clears it (the code loads only the group's used positions)
// [R02] a zero mask bit keeps its event bit off the summary
// [R03] summary is the OR of all set, unmasked event bits
// [R04] measurement mask positions B0 B1 B2 B5 B7 B8 B9 only
// [R05] questionable mask positions B4 B8 B14; B15 reads zero
// [R06] operation mask positions B4 B5 B10 only
// [R07] mask query returns the current mask value
// [R08] each group has a live condition register, same layout as events
// [R09] condition query returns the current condition bits
// [R10] preset clears all three masks
// [R11] preset touches nothing else
// [R12] queue is first-in first-out; a read returns and removes the oldest
// [R13] queue holds at most ten entries
// [R14] filling the queue puts code 350 in the last slot
// [R15] queue is empty after power-up
// [R16] reading an empty queue returns code 0
// [R17] codes are signed: negative standard, positive vendor
// [R18] clear empties the queue
// [R19] at power-up only negative codes are admitted
// [R20] enable list disables all, then enables listed codes
// [R21] disable list blocks listed codes; query returns them
// [R22] host sends lists as singles, ranges, or mixed
// [R23] reading an event register clears it
// [R24] a full queue discards arrivals until read or cleared
// [R25] event bit latches on condition rise, holds until read
module status_mask_and_error_queue import status_pkg::*; #(
	parameter int QDEPTH = QUEUE_DEPTH,
	parameter int NLIST  = LIST_ENTRIES
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// status sources, asynchronous
	input  wire logic [DATA_W-1:0] measSource,
	input  wire logic [DATA_W-1:0] quesSource,
	input  wire logic [DATA_W-1:0] operSource,
	// host commands
	input  wire logic              cmdValid,
	input  wire cmd_op_t           cmdOp,
	input  wire logic [1:0]        cmdSel,
	input  wire logic [RSP_W-1:0]  cmdData,
	// arriving messages
	input  wire logic              msgValid,
	input  wire logic [CODE_W-1:0] msgCode,
	// answers
	output logic                   rspValid,
	output logic [RSP_W-1:0]       rspData,
	output logic [2:0]             rspTag,
	// summaries to the next register set
	output logic                   measSummary,
	output logic                   quesSummary,
	output logic                   operSummary
);

	localparam int PW = $clog2(QDEPTH);
	localparam int CW = $clog2(QDEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(QDEPTH);
	localparam logic [CW-1:0] LAST_FREE  = CW'(QDEPTH - 1);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] usedBits(input logic [1:0] g);
		case (g)
			GRP_MEAS: usedBits = MEAS_USED;
			GRP_QUES: usedBits = QUES_USED;
			GRP_OPER: usedBits = OPER_USED;
			default:  usedBits = 16'h0000;
		endcase
	endfunction

	function automatic logic inRange(input logic [15:0] c, input logic [15:0] lo,
		input logic [15:0] hi);
		inRange = ($signed(c) >= $signed(lo)) && ($signed(c) <= $signed(hi));
	endfunction

	function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
		nextPtr = (p == PW'(QDEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	logic [GROUPS-1:0][15:0] srcMeta;
	logic [GROUPS-1:0][15:0] srcSync;
	logic [GROUPS-1:0][15:0] cond;
	logic [GROUPS-1:0][15:0] condPrev;
	logic [GROUPS-1:0][15:0] evt;
	logic [GROUPS-1:0][15:0] mask;
	logic [GROUPS-1:0]       summary;
	logic                    presetHit;

	assign presetHit = cmdValid && (cmdOp == OP_PRESET);

	// ----------------------------------------------------------------
	// condition registers
	// ----------------------------------------------------------------
	// sources are pins: two stages before anything looks at them
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			srcMeta  <= '0;
			srcSync  <= '0;
			cond     <= '0;
			condPrev <= '0;
		end else begin
			srcMeta <= {operSource, quesSource, measSource};
			srcSync <= srcMeta;
			for (int g = 0; g < GROUPS; g++) begin
				cond[g] <= srcSync[g] & usedBits(2'(g)); // [R08]
			end
			condPrev <= cond;
		end
	end

	// ----------------------------------------------------------------
	// event registers
	// ----------------------------------------------------------------
	// a rise in the read cycle survives the clear
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			evt <= {GROUPS{EVT_RESET}};
		end else begin
			for (int g = 0; g < GROUPS; g++) begin
				if (cmdValid && cmdOp == OP_EVENT_RD && cmdSel == 2'(g)) begin
					evt[g] <= cond[g] & ~condPrev[g]; // [R23] [R25]
				end else begin
					evt[g] <= evt[g] | (cond[g] & ~condPrev[g]); // [R25]
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// enable masks
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask <= {GROUPS{MASK_RESET}};
		end else if (presetHit) begin
			mask <= {GROUPS{MASK_RESET}}; // [R10] [R11]
		end else if (cmdValid && cmdOp == OP_MASK_WR) begin
			for (int g = 0; g < GROUPS; g++) begin
				if (cmdSel == 2'(g)) begin
					mask[g] <= cmdData[15:0] & usedBits(2'(g)); // [R01] [R04] [R05] [R06]
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			summary <= '0;
		end else begin
			for (int g = 0; g < GROUPS; g++) begin
				summary[g] <= |(evt[g] & mask[g]); // [R02] [R03]
			end
		end
	end

	assign measSummary = summary[0];
	assign quesSummary = summary[1];
	assign operSummary = summary[2];

	// ----------------------------------------------------------------
	// admission lists
	// ----------------------------------------------------------------
	logic [NLIST-1:0][15:0] listLo;
	logic [NLIST-1:0][15:0] listHi;
	logic [NLIST-1:0]       listUsed;
	logic [NLIST-1:0]       listEn;
	logic                   defaultMode;
	logic                   admit;
	logic                   hasFree;
	logic [$clog2(NLIST)-1:0] freeIdx;

	always_comb begin
		logic enHit;
		logic disHit;
		enHit   = 1'b0;
		disHit  = 1'b0;
		hasFree = 1'b0;
		freeIdx = '0;
		for (int i = NLIST - 1; i >= 0; i--) begin
			if (listUsed[i] && inRange(msgCode, listLo[i], listHi[i])) begin
				if (listEn[i]) begin
					enHit = 1'b1;
				end else begin
					disHit = 1'b1;
				end
			end
			if (!listUsed[i]) begin
				hasFree = 1'b1;
				freeIdx = ($clog2(NLIST))'(i);
			end
		end
		// power-up default admits the negative (error) codes only
		admit = (defaultMode ? msgCode[15] : enHit) && !disHit; // [R17] [R19] [R21]
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			defaultMode <= 1'b1; // [R19]
			listUsed    <= '0;
			listEn      <= '0;
			listLo      <= '0;
			listHi      <= '0;
		end else if (cmdValid && cmdOp == OP_ENLIST_BEGIN) begin
			defaultMode <= 1'b0; // [R20]
			listUsed    <= listUsed & ~listEn;
		end else if (cmdValid && (cmdOp == OP_ENLIST_ADD || cmdOp == OP_DISLIST_ADD)
			&& hasFree) begin
			listUsed[freeIdx] <= 1'b1;
			listEn[freeIdx]   <= (cmdOp == OP_ENLIST_ADD); // [R20] [R21]
			listLo[freeIdx]   <= cmdData[31:16];
			listHi[freeIdx]   <= cmdData[15:0];
		end
	end

	// ----------------------------------------------------------------
	// error queue
	// ----------------------------------------------------------------
	queue_mem_if #(.WIDTH(CODE_W), .AW(PW)) qmem ();

	error_queue_mem #(.DEPTH(QDEPTH), .WIDTH(CODE_W)) u_store (
		.ref_clk (ref_clk),
		.mem     (qmem.store)
	);

	logic [PW-1:0] head;
	logic [PW-1:0] tail;
	logic [CW-1:0] count;
	logic          qPending;
	logic          qEmptyAtCmd;
	logic          push;
	logic          pop;
	logic          qClear;

	assign qClear = cmdValid && cmdOp == OP_QUEUE_CLR;
	assign pop    = qPending && !qEmptyAtCmd && !qClear; // [R12]
	assign push   = msgValid && admit && (count != FULL_COUNT) && !qClear; // [R24]

	assign qmem.wrEn   = push;
	assign qmem.wrAddr = tail;
	assign qmem.rdAddr = head;
	// the final free slot takes the overflow marker instead of the message
	assign qmem.wrData = (count == LAST_FREE && !pop) ? OVERFLOW_CODE : msgCode; // [R14]

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			head  <= '0;
			tail  <= '0;
			count <= '0; // [R15]
		end else if (qClear) begin
			head  <= '0; // [R18]
			tail  <= '0;
			count <= '0;
		end else begin
			if (push) begin
				tail <= nextPtr(tail);
			end
			if (pop) begin
				head <= nextPtr(head); // [R12]
			end
			count <= CW'(count + CW'(push) - CW'(pop)); // [R13]
		end
	end

	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	// queue reads answer one cycle later than the rest: the store has a read register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			qPending    <= 1'b0;
			qEmptyAtCmd <= 1'b0;
			rspValid    <= 1'b0;
			rspData     <= '0;
			rspTag      <= '0;
		end else begin
			qPending <= cmdValid && cmdOp == OP_QUEUE_RD;
			qEmptyAtCmd <= (count == '0);
			rspValid <= 1'b0;
			if (qPending) begin
				rspValid <= 1'b1;
				rspTag   <= '0;
				rspData  <= qEmptyAtCmd ? {{16{1'b0}}, NO_ERROR_CODE} // [R16]
					: {{16{qmem.rdData[15]}}, qmem.rdData}; // [R17]
			end else if (cmdValid) begin
				rspTag <= '0;
				case (cmdOp)
					OP_MASK_RD: begin
						rspValid <= 1'b1;
						rspData  <= (cmdSel == 2'h3) ? '0 : {16'h0000, mask[cmdSel]}; // [R07]
					end
					OP_COND_RD: begin
						rspValid <= 1'b1;
						rspData  <= (cmdSel == 2'h3) ? '0 : {16'h0000, cond[cmdSel]}; // [R09]
					end
					OP_EVENT_RD: begin
						rspValid <= 1'b1;
						rspData  <= (cmdSel == 2'h3) ? '0 : {16'h0000, evt[cmdSel]}; // [R23]
					end
					OP_LIST_RD: begin
						rspValid <= 1'b1;
						rspData  <= {listLo[cmdData[1:0]], listHi[cmdData[1:0]]}; // [R20] [R21]
						rspTag   <= {defaultMode, listUsed[cmdData[1:0]], listEn[cmdData[1:0]]};
					end
					default: begin
						rspValid <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	property p_mask_write;
		cmdValid && cmdOp == OP_MASK_WR && cmdSel == GRP_MEAS && !presetHit
			|=> mask[0] == ($past(cmdData[15:0]) & MEAS_USED);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // [R01]

	property p_blocked;
		(evt[0] & mask[0]) == 16'h0000 |=> !measSummary;
	endproperty
	a_blocked: assert property (p_blocked) else $error("masked event reached summary"); // [R02]

	property p_summary;
		|(evt[1] & mask[1]) |=> quesSummary;
	endproperty
	a_summary: assert property (p_summary) else $error("summary missed event"); // [R03]

	property p_unused_bits;
		(mask[0] & ~MEAS_USED) == 16'h0000 && (mask[1] & ~QUES_USED) == 16'h0000
			&& (mask[2] & ~OPER_USED) == 16'h0000;
	endproperty
	a_unused_bits: assert property (p_unused_bits) else $error("unused mask bit set"); // [R04]

	property p_mask_read;
		cmdValid && cmdOp == OP_MASK_RD && cmdSel == GRP_OPER && !qPending
			|=> rspValid && rspData[15:0] == $past(mask[2]);
	endproperty
	a_mask_read: assert property (p_mask_read) else $error("mask read wrong"); // [R07]

	property p_preset;
		presetHit |=> mask == '0;
	endproperty
	a_preset: assert property (p_preset) else $error("preset left a mask"); // [R10]

	property p_count_max;
		count <= FULL_COUNT;
	endproperty
	a_count_max: assert property (p_count_max) else $error("queue over depth"); // [R13]

	property p_overflow_mark;
		push && count == LAST_FREE && !pop |=> u_store.store[$past(tail)] == OVERFLOW_CODE;
	endproperty
	a_overflow_mark: assert property (p_overflow_mark) else $error("no overflow mark"); // [R14]

	property p_empty_read;
		cmdValid && cmdOp == OP_QUEUE_RD && count == '0 && !qPending
			|=> ##1 rspValid && rspData == 32'h0000_0000;
	endproperty
	a_empty_read: assert property (p_empty_read) else $error("empty read not zero"); // [R16]

	property p_clear;
		qClear |=> count == '0 ##1 !rspValid || count <= 1;
	endproperty
	a_clear: assert property (p_clear) else $error("clear left entries"); // [R18]

	property p_full_discard;
		count == FULL_COUNT && !qPending && !qClear |=> count == FULL_COUNT;
	endproperty
	a_full_discard: assert property (p_full_discard) else $error("full queue changed"); // [R24]

	c_overflow: cover property (push && count == LAST_FREE);
	c_summary: cover property (!measSummary ##1 measSummary);
	c_queue_read: cover property (qPending && !qEmptyAtCmd ##1 rspValid);
	c_list_add: cover property (cmdValid && cmdOp == OP_ENLIST_ADD && hasFree);

endmodule

// file: testbench/status_host.sv
// host computer model issuing status commands and collecting answers
`timescale 1ns/100ps
module status_host import status_pkg::*; (
	// clock
	input  wire logic             ref_clk,
	// commands
	output logic                  cmdValid,
	output cmd_op_t               cmdOp,
	output logic [1:0]            cmdSel,
	output logic [RSP_W-1:0]      cmdData,
	// answers
	input  wire logic             rspValid,
	input  wire logic [RSP_W-1:0] rspData,
	input  wire logic [2:0]       rspTag
);

	initial begin
		cmdValid = 1'b0;
		cmdOp = OP_NONE;
		cmdSel = 2'h0;
		cmdData = 32'h00000000;
	end

	// ----------------------------------------------------------------
	// command cycles
	// ----------------------------------------------------------------
	task automatic send(input cmd_op_t op, input logic [1:0] sel, input logic [RSP_W-1:0] data);
		@(posedge ref_clk);
		cmdValid <= 1'b1;
		cmdOp <= op;
		cmdSel <= sel;
		cmdData <= data;
		@(posedge ref_clk);
		cmdValid <= 1'b0;
		cmdOp <= OP_NONE;
	endtask

	// trailing edge keeps the two-cycle spacing after a queue read
	task automatic query(input cmd_op_t op, input logic [1:0] sel, input logic [RSP_W-1:0] data,
		output logic [RSP_W-1:0] d, output logic [2:0] t, output bit ok);
		ok = 1'b0;
		d = 32'h00000000;
		t = 3'h0;
		send(op, sel, data);
		for (int i = 0; i < 4 && !ok; i++) begin
			#1;
			if (rspValid === 1'b1) begin
				ok = 1'b1;
				d = rspData;
				t = rspTag;
			end else begin
				@(posedge ref_clk);
			end
		end
		@(posedge ref_clk);
	endtask

	// a single code is a range with equal ends
	task automatic list_add(input cmd_op_t op, input logic [15:0] lo, input logic [15:0] hi);
		send(op, 2'h0, {lo, hi});
	endtask

endmodule

// file: testbench/status_mask_and_error_queue_test.sv
// self-checking bench of the status and error queue block
`timescale 1ns/100ps
module status_mask_and_error_queue_test import status_pkg::*; ;

	logic              ref_clk;
	logic              arst_n;
	logic [DATA_W-1:0] srcVal [3];
	logic              cmdValid;
	cmd_op_t           cmdOp;
	logic [1:0]        cmdSel;
	logic [RSP_W-1:0]  cmdData;
	logic              msgValid;
	logic [CODE_W-1:0] msgCode;
	logic              rspValid;
	logic [RSP_W-1:0]  rspData;
	logic [2:0]        rspTag;
	logic              measSummary;
	logic              quesSummary;
	logic              operSummary;
	logic [2:0]        lastTag;
	logic [15:0]       mv [3];
	logic [15:0]       codes [12];
	logic [15:0]       n16;
	logic [31:0]       v;
	int                errorCnt;
	int                checksDone;

	status_mask_and_error_queue DUT (
		.ref_clk(ref_clk), .arst_n(arst_n),
		.measSource(srcVal[0]), .quesSource(srcVal[1]), .operSource(srcVal[2]),
		.cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSel(cmdSel), .cmdData(cmdData),
		.msgValid(msgValid), .msgCode(msgCode),
		.rspValid(rspValid), .rspData(rspData), .rspTag(rspTag),
		.measSummary(measSummary), .quesSummary(quesSummary), .operSummary(operSummary)
	);

	status_host hst (
		.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSel(cmdSel),
		.cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .rspTag(rspTag)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// expectations and checks
	// ----------------------------------------------------------------
	function automatic logic [15:0] usedBits(input int g);
		return (g == 0) ? MEAS_USED : (g == 1) ? QUES_USED : (g == 2) ? OPER_USED : 16'h0000;
	endfunction

	function automatic logic [31:0] sext(input logic [15:0] c);
		return {{16{c[15]}}, c};
	endfunction

	task automatic conclude();
		if (errorCnt == 0 && checksDone > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checksDone++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED %0t %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic qchk(input cmd_op_t op, input logic [1:0] sel, input logic [31:0] data,
		input logic [31:0] exp, input string msg);
		logic [31:0] d;
		bit          ok;
		hst.query(op, sel, data, d, lastTag, ok);
		if (!ok) begin
			errorCnt++;
			$display("CHECK FAILED %0t no answer to %s", $time, msg);
			conclude();
		end else begin
			chk(d, exp, msg);
		end
	endtask

	task automatic post(input logic [15:0] c);
		@(posedge ref_clk);
		msgValid <= 1'b1;
		msgCode <= c;
		@(posedge ref_clk);
		msgValid <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		errorCnt = 0;
		checksDone = 0;
		arst_n = 1'b0;
		msgValid = 1'b0;
		msgCode = 16'h0000;
		for (int g = 0; g < 3; g++) srcVal[g] = 16'h0000;
		void'($urandom(48475));
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		qchk(OP_QUEUE_RD, 2'h0, 32'h0, 32'h0, "empty queue after reset");
		// masks: random load, readback limited to used positions
		for (int g = 0; g < 3; g++) begin
			v = $urandom;
			mv[g] = v[15:0];
			hst.send(OP_MASK_WR, 2'(g), {16'h0000, mv[g]});
			v = {16'h0000, mv[g] & usedBits(g)};
			qchk(OP_MASK_RD, 2'(g), 32'h0, v, "mask read");
		end
		hst.send(OP_MASK_WR, 2'h3, 32'h0000FFFF);
		qchk(OP_MASK_RD, 2'h3, 32'h0, 32'h0, "unselected group");
		mv[0] = mv[0] | 16'h0200;
		hst.send(OP_MASK_WR, 2'h0, {16'h0000, mv[0]});
		// sources rise from zero so each used bit that the random value sets latches an event
		v = $urandom;
		srcVal[0] <= v[15:0] | 16'h0200;
		srcVal[1] <= v[31:16] | 16'h4000;
		v = $urandom;
		srcVal[2] <= v[15:0] | 16'h0400;
		repeat (6) @(posedge ref_clk);
		for (int g = 0; g < 3; g++) begin
			v = {16'h0000, srcVal[g] & usedBits(g)};
			qchk(OP_COND_RD, 2'(g), 32'h0, v, "condition");
		end
		// look after the edge, once the summaries have settled
		#1;
		chk({29'h0, measSummary, quesSummary, operSummary},
			{29'h0, |(srcVal[0] & usedBits(0) & mv[0]), |(srcVal[1] & usedBits(1) & mv[1]),
			|(srcVal[2] & usedBits(2) & mv[2])}, "summary");
		// preset clears masks only
		post(16'hFFF0);
		hst.send(OP_PRESET, 2'h0, 32'h0);
		repeat (3) @(posedge ref_clk);
		#1;
		chk({29'h0, measSummary, quesSummary, operSummary}, 32'h0,
			"summary after preset");
		for (int g = 0; g < 3; g++) begin
			v = {16'h0000, srcVal[g] & usedBits(g)};
			qchk(OP_MASK_RD, 2'(g), 32'h0, 32'h0, "mask after preset");
			qchk(OP_COND_RD, 2'(g), 32'h0, v, "cond kept");
			qchk(OP_EVENT_RD, 2'(g), 32'h0, v, "events");
			qchk(OP_EVENT_RD, 2'(g), 32'h0, 32'h0, "events cleared by read");
		end
		qchk(OP_QUEUE_RD, 2'h0, 32'h0, sext(16'hFFF0), "queue kept by preset");
		// fill past capacity; the tenth slot carries the overflow code
		for (int i = 0; i < 12; i++) begin
			n16 = 16'(1 + $urandom_range(499));
			codes[i] = 16'h0000 - n16;
			post(codes[i]);
			if (i == 4) post(16'h0007);
		end
		for (int i = 0; i < 10; i++) begin
			v = (i < 9) ? sext(codes[i]) : sext(OVERFLOW_CODE);
			qchk(OP_QUEUE_RD, 2'h0, 32'h0, v, "queue order");
		end
		qchk(OP_QUEUE_RD, 2'h0, 32'h0, 32'h0, "queue drained");
		post(codes[0]);
		post(codes[1]);
		hst.send(OP_QUEUE_CLR, 2'h0, 32'h0);
		qchk(OP_QUEUE_RD, 2'h0, 32'h0, 32'h0, "queue cleared");
		// empty enable list admits nothing
		hst.send(OP_ENLIST_BEGIN, 2'h0, 32'h0);
		post(16'hFFF9);
		qchk(OP_QUEUE_RD, 2'h0, 32'h0, 32'h0, "empty enable list");
		hst.list_add(OP_ENLIST_ADD, 16'hFF22, 16'hFF92);
		hst.list_add(OP_DISLIST_ADD, 16'hFF6A, 16'hFF6A);
		post(16'hFF6A);
		post(16'hFF88);
		post(16'h0005);
		post(16'hFED4);
		qchk(OP_QUEUE_RD, 2'h0, 32'h0, sext(16'hFF88), "enabled range");
		qchk(OP_QUEUE_RD, 2'h0, 32'h0, 32'h0, "others blocked");
		qchk(OP_LIST_RD, 2'h0, 32'h0, 32'hFF22FF92, "enable entry");
		chk({29'h0, lastTag}, 32'h3, "enable entry tag");
		qchk(OP_LIST_RD, 2'h0, 32'h1, 32'hFF6AFF6A, "disable entry");
		chk({29'h0, lastTag}, 32'h2, "disable entry tag");
		conclude();
	end

endmodule
